// ==== design/feature_cfg_pkg.sv ====
// shared constants and types for the feature bit configuration store
package feature_cfg_pkg;
    localparam logic [7:0] reg_unlock_key = 8'h08;
    localparam logic [7:0] reg_bit_select = 8'h09;
    localparam logic [7:0] reg_bit_write = 8'h0a;
    localparam logic [7:0] unlock_key_value = 8'hbb;
    localparam logic [7:0] write_set_one = 8'h82;
    localparam logic [7:0] write_set_zero = 8'h80;
    localparam logic [7:0] write_commit = 8'h00;
    localparam logic [7:0] reg_reset_value = 8'h00;
    localparam int num_outputs = 19;
    localparam int trim_width = 4;
    localparam int trim_base_bit = 140;
    localparam logic [7:0] bypass_delay_bit = 8'hde;
    localparam int feature_bits = 256;
    localparam logic [feature_bits-1:0] feature_reset = '0;
    localparam logic [3:0] bits_per_byte = 4'h8;
    // arbitrary 7-bit bus address, not tied to any real part
    localparam logic [6:0] smbus_dev_addr = 7'h69;
    localparam logic [6:0] level_full = 7'h64;

    typedef struct packed {
        logic valid;
        logic [7:0] cmd;
        logic [7:0] data;
    } reg_wr_t;
endpackage

// ==== design/trim_level_decoder.sv ====
// registered decode of one output's 4-bit drive trim to a percentage
`timescale 1ns/100ps
module trim_level_decoder (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] trim,
    output logic [6:0] level_pct_q
);
    logic [6:0] level_d;

    always_comb begin
        case (trim)
            4'h0: level_d = 7'h64;
            4'h1: level_d = 7'h5a;
            4'h3: level_d = 7'h50;
            4'h4: level_d = 7'h46;
            4'h6: level_d = 7'h3c;
            4'h7: level_d = 7'h32;
            4'ha: level_d = 7'h28;
            4'hb: level_d = 7'h1e;
            4'hc: level_d = 7'h14;
            4'he: level_d = 7'h0a;
            4'hf: level_d = 7'h00;
            // undefined codes keep full drive rather than guess a level
            default: level_d = 7'h64;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            level_pct_q <= feature_cfg_pkg::level_full;
        end else begin
            level_pct_q <= level_d;
        end
    end
endmodule // trim_level_decoder

// ==== design/feature_bit_config_store.sv ====
// smbus-reached indirect feature bit store with drive trim and bypass delay outputs
`timescale 1ns/100ps
module feature_bit_config_store (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic bypass_fast_q,
    output logic [4*19-1:0] drive_trim_q,
    output logic [7*19-1:0] drive_level_q
);
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_CMD, S_WDATA, S_RDATA, S_IGNORE} bus_state_t;

    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_prev_q;
    logic sda_prev_q;
    bus_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic ack_phase_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [7:0] cmd_q;
    logic sda_oe_q;
    feature_cfg_pkg::reg_wr_t wr_q;
    logic [7:0] key_q;
    logic [7:0] sel_q;
    logic arm_q;
    logic arm_val_q;
    logic [feature_cfg_pkg::feature_bits-1:0] bits_q;

    wire scl_s = scl_sync_q[1];
    wire sda_s = sda_sync_q[1];
    wire scl_rise = scl_s & ~scl_prev_q;
    wire scl_fall = ~scl_s & scl_prev_q;
    wire bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    wire bus_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    wire byte_done = scl_fall & ~ack_phase_q & (bit_cnt_q == feature_cfg_pkg::bits_per_byte);
    wire addr_match = (shift_q[7:1] == feature_cfg_pkg::smbus_dev_addr);
    wire unlocked = (key_q == feature_cfg_pkg::unlock_key_value);
    wire wr_key = wr_q.valid & (wr_q.cmd == feature_cfg_pkg::reg_unlock_key);
    wire wr_sel = wr_q.valid & unlocked & (wr_q.cmd == feature_cfg_pkg::reg_bit_select);
    wire wr_bit = wr_q.valid & unlocked & (wr_q.cmd == feature_cfg_pkg::reg_bit_write);
    wire is_arm_one = (wr_q.data == feature_cfg_pkg::write_set_one);
    wire is_arm_zero = (wr_q.data == feature_cfg_pkg::write_set_zero);
    wire is_commit = (wr_q.data == feature_cfg_pkg::write_commit) & arm_q;
    wire sel_bit = bits_q[sel_q];
    wire [7:0] rd_value = (cmd_q == feature_cfg_pkg::reg_unlock_key) ? key_q :
                          (cmd_q == feature_cfg_pkg::reg_bit_select) ? sel_q :
                          (cmd_q == feature_cfg_pkg::reg_bit_write) ? {7'h00, sel_bit} :
                          feature_cfg_pkg::reg_reset_value;

    // pins come from another domain, so two flops before anything looks at them
    always_ff @(posedge mclk) begin
        if (rst) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'h1;
            sda_prev_q <= 1'h1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= S_IDLE;
            bit_cnt_q <= 4'h0;
            ack_phase_q <= 1'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            cmd_q <= 8'h00;
            sda_oe_q <= 1'h0;
            wr_q <= '0;
        end else begin
            wr_q.valid <= 1'h0;
            if (bus_start) begin
                state_q <= S_ADDR;
                bit_cnt_q <= 4'h0;
                ack_phase_q <= 1'h0;
                sda_oe_q <= 1'h0;
            end else if (bus_stop) begin
                state_q <= S_IDLE;
                sda_oe_q <= 1'h0;
                ack_phase_q <= 1'h0;
            end else if (state_q != S_IDLE) begin
                if (scl_rise && !ack_phase_q && bit_cnt_q < feature_cfg_pkg::bits_per_byte) begin
                    shift_q <= {shift_q[6:0], sda_s};
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end
                if (scl_fall && ack_phase_q) begin
                    ack_phase_q <= 1'h0;
                    bit_cnt_q <= 4'h0;
                    sda_oe_q <= (state_q == S_RDATA) ? ~tx_q[7] : 1'h0;
                    if (state_q == S_RDATA) begin
                        tx_q <= {tx_q[6:0], 1'h0};
                    end
                end else if (byte_done) begin
                    ack_phase_q <= 1'h1;
                    sda_oe_q <= 1'h1;
                    case (state_q)
                        S_ADDR: begin
                            if (!addr_match) begin
                                state_q <= S_IGNORE;
                                sda_oe_q <= 1'h0;
                            end else if (shift_q[0]) begin
                                state_q <= S_RDATA;
                                tx_q <= rd_value;
                            end else begin
                                state_q <= S_CMD;
                            end
                        end
                        S_CMD: begin
                            cmd_q <= shift_q;
                            state_q <= S_WDATA;
                        end
                        S_WDATA: begin
                            wr_q.valid <= 1'h1;
                            wr_q.cmd <= cmd_q;
                            wr_q.data <= shift_q;
                        end
                        S_RDATA: begin
                            // single-byte read: release for the host's ack, then go quiet
                            sda_oe_q <= 1'h0;
                            state_q <= S_IGNORE;
                        end
                        default: begin
                            sda_oe_q <= 1'h0;
                        end
                    endcase
                end else if (scl_fall && state_q == S_RDATA && bit_cnt_q != 4'h0) begin
                    sda_oe_q <= ~tx_q[7];
                    tx_q <= {tx_q[6:0], 1'h0};
                end
            end
        end
    end

    // register file: key, select, and the two-write bit update
    always_ff @(posedge mclk) begin
        if (rst) begin
            key_q <= feature_cfg_pkg::reg_reset_value;
            sel_q <= feature_cfg_pkg::reg_reset_value;
            arm_q <= 1'h0;
            arm_val_q <= 1'h0;
            bits_q <= feature_cfg_pkg::feature_reset;
        end else begin
            if (wr_key) begin
                key_q <= wr_q.data;
            end
            if (wr_sel) begin
                sel_q <= wr_q.data;
            end
            if (wr_bit) begin
                // any byte other than the arming pair drops a half-done update
                arm_q <= is_arm_one | is_arm_zero;
                arm_val_q <= is_arm_one;
                if (is_commit) begin
                    bits_q[sel_q] <= arm_val_q;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            bypass_fast_q <= 1'h0;
            drive_trim_q <= '0;
        end else begin
            bypass_fast_q <= bits_q[feature_cfg_pkg::bypass_delay_bit];
            drive_trim_q <= bits_q[feature_cfg_pkg::trim_base_bit +: 4*19];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < feature_cfg_pkg::num_outputs; gi++) begin : g_trim
            trim_level_decoder u_dec (
                .mclk(mclk),
                .rst(rst),
                .trim(bits_q[feature_cfg_pkg::trim_base_bit + 4*gi +: 4]),
                .level_pct_q(drive_level_q[7*gi +: 7])
            );
        end
    endgenerate

    assign sda_o = 1'h0;
    assign sda_oe = sda_oe_q;
endmodule // feature_bit_config_store

// ==== tb/fbcs_properties.sv ====
// port assertions for the feature bit store
`timescale 1ns/100ps
module fbcs_properties (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic bypass_fast_q,
    input wire logic [4*19-1:0] drive_trim_q,
    input wire logic [7*19-1:0] drive_level_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    function automatic logic [6:0] lvl(input logic [3:0] c);
        logic [6:0] t [16] = '{7'h64, 7'h5a, 7'h64, 7'h50, 7'h46, 7'h64, 7'h3c, 7'h32,
            7'h64, 7'h64, 7'h28, 7'h1e, 7'h14, 7'h64, 7'h0a, 7'h00};
        return t[c];
    endfunction
    sequence s_ack_hold;
        sda_oe [*4];
    endsequence
    a_reset_clears_all: assert property (disable iff (1'b0) rst |=>
        !bypass_fast_q && drive_trim_q == '0 && drive_level_q == {19{7'h64}} && !sda_oe)
        else $error("outputs not default after reset");
    // trim and level are both registered straight from the stored bits, so they move together
    a_level_out_first: assert property (!$past(rst) |->
        drive_level_q[6:0] == lvl(drive_trim_q[3:0])) else $error("level 0 wrong");
    a_level_out_last: assert property (!$past(rst) |->
        drive_level_q[132:126] == lvl(drive_trim_q[75:72])) else $error("level 18 wrong");
    a_one_bit_commit: assert property ($changed(drive_trim_q) |->
        $onehot(drive_trim_q ^ $past(drive_trim_q))) else $error("several trim bits moved");
    a_bypass_alone: assert property ($changed(bypass_fast_q) |->
        $stable(drive_trim_q)) else $error("bypass moved with trim");
    a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_i)
        else $error("ack raised while clock high");
    a_ack_holds_on: assert property ($rose(sda_oe) |=> s_ack_hold)
        else $error("ack dropped early");
    a_open_drain_low: assert property (sda_oe |-> !sda_o)
        else $error("data driven high");
endmodule // fbcs_properties
bind feature_bit_config_store fbcs_properties i_fbcs_properties (.mclk(mclk), .rst(rst),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .bypass_fast_q(bypass_fast_q), .drive_trim_q(drive_trim_q), .drive_level_q(drive_level_q));

// ==== tb/smbus_host_model.sv ====
// serial bus host that reaches the feature store registers
`timescale 1ns/100ps
module smbus_host_model (
    input wire logic mclk,
    input wire logic dev_oe,
    output logic scl,
    output logic sda_line
);
    logic pull_q = 1'b0;
    initial scl = 1'b1;
    // pulled-up wire: whoever pulls wins, so a released line reads high
    assign sda_line = !(pull_q || dev_oe);
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // phases of 6 clocks keep clear of the 4-clock minimum
    task automatic clk_bit(input logic b, output logic s);
        wt(1);
        pull_q <= !b;
        wt(6);
        scl <= 1'b1;
        wt(6);
        s = sda_line;
        scl <= 1'b0;
    endtask
    task automatic start();
        wt(1);
        pull_q <= 1'b0;
        wt(6);
        scl <= 1'b1;
        wt(6);
        pull_q <= 1'b1;
        wt(6);
        scl <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] b, output logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
            d[i] = s;
        end
        clk_bit(1'b1, s);
        ack = !s;
    endtask
    task automatic access(input logic rd, input logic [7:0] c, inout logic [7:0] d,
        output logic ok);
        logic [7:0] x;
        logic a0, a1, a2;
        start();
        xfer({feature_cfg_pkg::smbus_dev_addr, 1'b0}, x, a0);
        xfer(c, x, a1);
        if (rd) begin
            start();
            xfer({feature_cfg_pkg::smbus_dev_addr, 1'b1}, x, a2);
            xfer(8'hff, d, x[0]);
        end else begin
            xfer(d, x, a2);
        end
        wt(1);
        pull_q <= 1'b1;
        wt(6);
        scl <= 1'b1;
        wt(6);
        pull_q <= 1'b0;
        wt(6);
        ok = a0 && a1 && a2;
    endtask
endmodule // smbus_host_model

// ==== tb/tb_feature_bit_config_store.sv ====
// self-checking bench for the feature bit store
`timescale 1ns/100ps
module tb_feature_bit_config_store;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic scl, sda, sda_o, sda_oe, bypass_fast_q, ok;
    logic [75:0] drive_trim_q, trim_exp;
    logic [132:0] drive_level_q, lvl_exp;
    logic [7:0] rd;
    int err_total = 0;
    int total_checks = 0;
    logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h6, 4'h7, 4'ha, 4'hb, 4'hc, 4'he, 4'hf};
    logic [6:0] pcts [11] = '{7'h64, 7'h5a, 7'h50, 7'h46, 7'h3c, 7'h32, 7'h28, 7'h1e, 7'h14,
        7'h0a, 7'h00};
    initial forever #10 mclk = ~mclk;
    smbus_host_model i_smbus_host_model (.mclk(mclk), .dev_oe(sda_oe), .scl(scl),
        .sda_line(sda));
    feature_bit_config_store i_feature_bit_config_store (.mclk(mclk), .rst(rst), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .bypass_fast_q(bypass_fast_q),
        .drive_trim_q(drive_trim_q), .drive_level_q(drive_level_q));
    task automatic chk_val(input string what, input logic [132:0] exp, input logic [132:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        i_smbus_host_model.access(1'b0, c, d, ok);
        chk_val("write ack", 133'(1), 133'(ok));
    endtask
    task automatic chk_reg(input logic [7:0] c, input logic [7:0] exp);
        i_smbus_host_model.access(1'b1, c, rd, ok);
        chk_val("read", {1'b1, exp}, {ok, rd});
    endtask
    task automatic set_bit(input logic [7:0] a, input logic v);
        wr(8'h09, a);
        wr(8'h0a, v ? 8'h82 : 8'h80);
        wr(8'h0a, 8'h00);
        if (a >= 8'h8c && a <= 8'hd7) trim_exp[a - 8'h8c] = v;
    endtask
    task automatic chk_outs(input logic byp);
        repeat (4) @(posedge mclk);
        for (int n = 0; n < 19; n++) begin
            lvl_exp[7*n +: 7] = 7'h64;
            for (int k = 0; k < 11; k++) begin
                if (trim_exp[4*n +: 4] == codes[k]) lvl_exp[7*n +: 7] = pcts[k];
            end
        end
        chk_val("bypass", 133'(byp), 133'(bypass_fast_q));
        chk_val("sda out", 133'(0), 133'(sda_o));
        chk_val("trim", 133'(trim_exp), 133'(drive_trim_q));
        chk_val("level", lvl_exp, drive_level_q);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        // the full sequence needs roughly 36000 clocks
        repeat (60000) @(posedge mclk);
        err_total++;
        final_report();
    end
    initial begin
        trim_exp = '0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        chk_outs(1'b0);
        wr(8'h09, 8'h91);
        chk_reg(8'h09, 8'h00);
        chk_reg(8'h0b, 8'h00);
        wr(8'h08, 8'hbb);
        chk_reg(8'h08, 8'hbb);
        // last code lands on output 18 to reach the top field
        for (int k = 1; k < 11; k++) for (int b = 0; b < 4; b++) if (codes[k][b])
            set_bit(8'(140 + 4 * (k == 10 ? 18 : k) + b), 1'b1);
        chk_outs(1'b0);
        set_bit(8'hd4, 1'b0);
        // a stray byte between arm and commit must leave bit 142 alone
        wr(8'h09, 8'h8e);
        wr(8'h0a, 8'h82);
        wr(8'h0a, 8'h11);
        wr(8'h0a, 8'h00);
        // output 0 lands on undefined code 0010, which keeps full drive
        set_bit(8'h8d, 1'b1);
        set_bit(8'hde, 1'b1);
        chk_reg(8'h0a, 8'h01);
        chk_outs(1'b1);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        trim_exp = '0;
        chk_outs(1'b0);
        chk_reg(8'h08, 8'h00);
        final_report();
    end
endmodule // tb_feature_bit_config_store
